// ---- core/fcsu_pkg.sv ----
// Package: command codes, status bits, register map and timing for the flash command host
`default_nettype none
package fcsu_pkg;
	localparam logic [7:0] FCSU_CMD_READ_ARRAY   = 8'hFF;
	localparam logic [7:0] FCSU_CMD_IDENT        = 8'h90;
	localparam logic [7:0] FCSU_CMD_READ_STATUS  = 8'h70;
	localparam logic [7:0] FCSU_CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] FCSU_CMD_PROG_SETUP   = 8'h40;
	localparam logic [7:0] FCSU_CMD_PROG_ALT     = 8'h10;
	localparam logic [7:0] FCSU_CMD_ERASE_SETUP  = 8'h20;
	localparam logic [7:0] FCSU_CMD_CONFIRM      = 8'hD0;
	localparam logic [7:0] FCSU_CMD_SUSPEND      = 8'hB0;
	// Status bit positions
	localparam int FCSU_SR_READY   = 7;
	localparam int FCSU_SR_PAUSED  = 6;
	localparam int FCSU_SR_EFAIL   = 5;
	localparam int FCSU_SR_PFAIL   = 4;
	localparam int FCSU_SR_SUPPLY  = 3;
	localparam logic [7:0] FCSU_SR_MASK = 8'hF8;
	// Host operation codes written to the control register
	localparam logic [2:0] FCSU_OP_READ_ARRAY  = 3'h0;
	localparam logic [2:0] FCSU_OP_READ_IDENT  = 3'h1;
	localparam logic [2:0] FCSU_OP_READ_STATUS = 3'h2;
	localparam logic [2:0] FCSU_OP_CLEAR       = 3'h3;
	localparam logic [2:0] FCSU_OP_PROGRAM     = 3'h4;
	localparam logic [2:0] FCSU_OP_ERASE       = 3'h5;
	localparam logic [2:0] FCSU_OP_SUSPEND     = 3'h6;
	localparam logic [2:0] FCSU_OP_RESUME      = 3'h7;
	// AXI register byte offsets
	localparam logic [4:0] FCSU_REG_CTRL   = 5'h00;
	localparam logic [4:0] FCSU_REG_ADDR   = 5'h04;
	localparam logic [4:0] FCSU_REG_WDATA  = 5'h08;
	localparam logic [4:0] FCSU_REG_RDATA  = 5'h0C;
	localparam logic [4:0] FCSU_REG_STATUS = 5'h10;
	// Pin strobe timing
	localparam int FCSU_CLK_MHZ     = 40;
	localparam int FCSU_STROBE_NS   = 100;
	localparam int FCSU_STROBE_CYC  = (FCSU_STROBE_NS * FCSU_CLK_MHZ + 999) / 1000;
	localparam int FCSU_RECOVER_NS  = 50;
	localparam int FCSU_RECOVER_CYC = (FCSU_RECOVER_NS * FCSU_CLK_MHZ + 999) / 1000;
	localparam logic [7:0] FCSU_CTRL_RESET = 8'h00;
endpackage : fcsu_pkg
`default_nettype wire

// ---- core/fcsu_bus_if.sv ----
// Interface: one pin cycle request from the sequencer to the pin driver
`timescale 1ns/1ps
`default_nettype none
interface fcsu_bus_if #(parameter int AW = 20);
	logic          req;
	logic          wr;
	logic [AW-1:0] addr;
	logic [15:0]   wdata;
	logic          done;
	logic [15:0]   rdata;
	modport master (output req, output wr, output addr, output wdata,
		input done, input rdata);
	modport slave (input req, input wr, input addr, input wdata,
		output done, output rdata);
endinterface : fcsu_bus_if
`default_nettype wire

// ---- core/fcsu_pin_cycle.sv ----
// Pin driver: one read or write cycle on the flash parallel bus
`timescale 1ns/1ps
`default_nettype none
module fcsu_pin_cycle
	import fcsu_pkg::*;
#(
	parameter int AW = 20
) (
	input  wire logic          clock,
	input  wire logic          srst,
	fcsu_bus_if.slave          bus,
	output logic [AW-1:0]      mem_addr,
	output logic               mem_ce_n,
	output logic               mem_oe_n,
	output logic               mem_we_n,
	output logic [15:0]        mem_dq_out,
	output logic               mem_dq_oe,
	input  wire logic [15:0]   mem_dq_in
);
	typedef enum logic [2:0] {
		FCSU_PC_IDLE   = 3'b001,
		FCSU_PC_STROBE = 3'b010,
		FCSU_PC_REST   = 3'b100
	} fcsu_pc_state_t;

	fcsu_pc_state_t state;
	logic [7:0]     cnt;
	logic           is_wr;

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= FCSU_PC_IDLE;
			cnt   <= 8'h00;
			is_wr <= 1'b0;
		end else begin
			case (state)
				FCSU_PC_IDLE: begin
					if (bus.req) begin
						state <= FCSU_PC_STROBE;
						cnt   <= 8'(FCSU_STROBE_CYC - 1);
						is_wr <= bus.wr;
					end
				end
				FCSU_PC_STROBE: begin
					if (cnt == 8'h00) begin
						state <= FCSU_PC_REST;
						cnt   <= 8'(FCSU_RECOVER_CYC - 1);
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				FCSU_PC_REST: begin
					if (cnt == 8'h00) begin
						state <= FCSU_PC_IDLE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				default: state <= FCSU_PC_IDLE;
			endcase
		end
	end

	// Chip select and output gate drop per read, so each status poll is fresh
	always_ff @(posedge clock) begin // [RULE17]
		if (srst) begin
			mem_ce_n   <= 1'b1;
			mem_oe_n   <= 1'b1;
			mem_we_n   <= 1'b1;
			mem_dq_oe  <= 1'b1;
			mem_dq_out <= 16'h0000;
			mem_addr   <= '0;
		end else if (state == FCSU_PC_IDLE && bus.req) begin
			mem_addr   <= bus.addr;
			mem_ce_n   <= 1'b0;
			mem_oe_n   <= bus.wr;
			mem_we_n   <= ~bus.wr;
			mem_dq_oe  <= ~bus.wr;
			mem_dq_out <= bus.wdata; // [RULE16]
		end else if (state == FCSU_PC_STROBE && cnt == 8'h00) begin
			mem_ce_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_we_n <= 1'b1;
		end else if (state == FCSU_PC_REST && cnt == 8'h00) begin
			mem_dq_oe <= 1'b1;
		end
	end

	// Read data taken just before the strobes rise
	always_ff @(posedge clock) begin
		if (srst) begin
			bus.rdata <= 16'h0000;
		end else if (state == FCSU_PC_STROBE && cnt == 8'h00 && !is_wr) begin
			bus.rdata <= mem_dq_in;
		end
	end

	assign bus.done = (state == FCSU_PC_REST) && (cnt == 8'h00);

	AST_STROBE_LEN: assert property (@(posedge clock) disable iff (srst) // [RULE17]
		$fell(mem_ce_n) |-> !mem_ce_n [*2] ##1 !mem_ce_n [*2])
		else $error("chip select strobe too short");
endmodule : fcsu_pin_cycle
`default_nettype wire

// ---- core/fcsu_host.sv ----
// Flash command host: AXI4-Lite registers and command sequencer for a boot-block flash
// Summary of operation
// RULE1 - Fail flags only clear by sending clear-status code 50.
// RULE2 - Fail flags accumulate over operations until the host clears them.
// RULE3 - After code 90, read address bit 0 selects maker or device code.
// RULE4 - After code 70, every read returns status until another command.
// RULE5 - Code FF returns to array read; host sends it before array reads.
// RULE6 - Program: setup 40 or 10 at target, then target address and data.
// RULE7 - Erase: code 20 then D0, both at an address in the block.
// RULE8 - Suspend is code B0, resume is D0; suspend sets ready and paused.
// RULE9 - Paused flag stays one until resume is written.
// RULE10 - Status bit 7 is one when ready, zero when busy.
// RULE11 - Host tests ready first, then examines the fail bits.
// RULE12 - Status bit 5 flags a failed block erase.
// RULE13 - Status bit 4 flags a failed program.
// RULE14 - Status bit 3 flags low supply, sampled only after a sequence.
// RULE15 - Status bits 2 to 0 are reserved; host masks them.
// RULE16 - Host drives the upper data byte to valid levels on command writes.
// RULE17 - Status latches on strobe fall; host toggles strobes per read.
// RULE18 - Upper byte reads zero during status reads in word mode.
// RULE19 - Non-confirm after erase setup sets both fail bits, status mode.
`timescale 1ns/1ps
`default_nettype none
module fcsu_host
	import fcsu_pkg::*;
#(
	parameter int AW = 20
) (
	input  wire logic          clock,
	input  wire logic          srst,
	input  wire logic [4:0]    s_axi_awaddr,
	input  wire logic          s_axi_awvalid,
	output logic               s_axi_awready,
	input  wire logic [31:0]   s_axi_wdata,
	input  wire logic [3:0]    s_axi_wstrb,
	input  wire logic          s_axi_wvalid,
	output logic               s_axi_wready,
	output logic [1:0]         s_axi_bresp,
	output logic               s_axi_bvalid,
	input  wire logic          s_axi_bready,
	input  wire logic [4:0]    s_axi_araddr,
	input  wire logic          s_axi_arvalid,
	output logic               s_axi_arready,
	output logic [31:0]        s_axi_rdata,
	output logic [1:0]         s_axi_rresp,
	output logic               s_axi_rvalid,
	input  wire logic          s_axi_rready,
	output logic [AW-1:0]      mem_addr,
	output logic               mem_ce_n,
	output logic               mem_oe_n,
	output logic               mem_we_n,
	output logic [15:0]        mem_dq_out,
	output logic               mem_dq_oe,
	input  wire logic [15:0]   mem_dq_in
);
	typedef enum logic [6:0] {
		FCSU_IDLE   = 7'b0000001,
		FCSU_CMD1   = 7'b0000010,
		FCSU_CMD2   = 7'b0000100,
		FCSU_POLLC  = 7'b0001000,
		FCSU_POLL   = 7'b0010000,
		FCSU_READ   = 7'b0100000,
		FCSU_FIN    = 7'b1000000
	} fcsu_state_t;

	fcsu_state_t    state;
	fcsu_bus_if #(.AW(AW)) pin ();

	logic [2:0]     op;
	logic [AW-1:0]  target;
	logic [15:0]    wvalue;
	logic [15:0]    rvalue;
	logic [7:0]     operation_status;
	logic           busy;
	logic           wait_ready;
	logic           ready_seen;
	logic           start;

	// AXI write channel: both address and data held until taken together
	logic           wr_go;
	logic [4:0]     wr_addr;
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign wr_addr       = s_axi_awaddr;
	assign start = wr_go && wr_addr == FCSU_REG_CTRL && s_axi_wstrb[0] && s_axi_wdata[7] && !busy;

	always_ff @(posedge clock) begin
		if (srst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (wr_addr == FCSU_REG_CTRL || wr_addr == FCSU_REG_ADDR
				|| wr_addr == FCSU_REG_WDATA) begin
				s_axi_bresp <= 2'b00;
			end else begin
				s_axi_bresp <= 2'b10;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			target <= '0;
			wvalue <= 16'h0000;
			op     <= FCSU_OP_READ_ARRAY;
		end else if (wr_go && !busy) begin
			if (wr_addr == FCSU_REG_CTRL) begin
				if (s_axi_wstrb[0]) begin
					op <= s_axi_wdata[2:0];
				end
			end else if (wr_addr == FCSU_REG_ADDR) begin
				target <= s_axi_wdata[AW-1:0];
			end else if (wr_addr == FCSU_REG_WDATA) begin
				wvalue <= s_axi_wdata[15:0];
			end
		end
	end

	// AXI read channel
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clock) begin
		if (srst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			if (s_axi_araddr == FCSU_REG_CTRL) begin
				s_axi_rdata <= {23'h000000, busy, 5'h00, op};
			end else if (s_axi_araddr == FCSU_REG_ADDR) begin
				s_axi_rdata <= 32'(target);
			end else if (s_axi_araddr == FCSU_REG_WDATA) begin
				s_axi_rdata <= {16'h0000, wvalue};
			end else if (s_axi_araddr == FCSU_REG_RDATA) begin
				s_axi_rdata <= {16'h0000, rvalue};
			end else if (s_axi_araddr == FCSU_REG_STATUS) begin
				s_axi_rdata <= {24'h000000, operation_status};
			end else begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= 2'b10;
			end
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Commands that need a completion poll
	assign wait_ready = (op == FCSU_OP_PROGRAM) || (op == FCSU_OP_ERASE)
		|| (op == FCSU_OP_SUSPEND) || (op == FCSU_OP_RESUME);
	// Resume skips the poll; the erase may take seconds, so software polls on
	assign ready_seen = pin.rdata[FCSU_SR_READY]; // [RULE10] [RULE11]

	function automatic logic [7:0] first_code(input logic [2:0] o);
		case (o)
			FCSU_OP_READ_ARRAY:  first_code = FCSU_CMD_READ_ARRAY; // [RULE5]
			FCSU_OP_READ_IDENT:  first_code = FCSU_CMD_IDENT; // [RULE3]
			FCSU_OP_READ_STATUS: first_code = FCSU_CMD_READ_STATUS; // [RULE4]
			FCSU_OP_CLEAR:       first_code = FCSU_CMD_CLEAR_STATUS; // [RULE1] [RULE2]
			FCSU_OP_PROGRAM:     first_code = FCSU_CMD_PROG_SETUP; // [RULE6]
			FCSU_OP_ERASE:       first_code = FCSU_CMD_ERASE_SETUP; // [RULE7]
			FCSU_OP_SUSPEND:     first_code = FCSU_CMD_SUSPEND; // [RULE8]
			default:             first_code = FCSU_CMD_CONFIRM; // [RULE9]
		endcase
	endfunction

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= FCSU_IDLE;
		end else begin
			case (state)
				FCSU_IDLE: begin
					if (start) begin
						state <= FCSU_CMD1;
					end
				end
				FCSU_CMD1: begin
					if (pin.done) begin
						if (op == FCSU_OP_PROGRAM || op == FCSU_OP_ERASE) begin
							state <= FCSU_CMD2;
						end else if (wait_ready && op != FCSU_OP_RESUME) begin
							state <= FCSU_POLL;
						end else if (op == FCSU_OP_READ_ARRAY || op == FCSU_OP_CLEAR
							|| op == FCSU_OP_RESUME) begin
							state <= FCSU_FIN;
						end else begin
							state <= FCSU_READ;
						end
					end
				end
				FCSU_CMD2: begin
					if (pin.done) begin
						state <= FCSU_POLL;
					end
				end
				FCSU_POLL: begin
					if (pin.done) begin
						state <= FCSU_POLLC;
					end
				end
				FCSU_POLLC: begin
					state <= ready_seen ? FCSU_FIN : FCSU_POLL; // [RULE11] [RULE17]
				end
				FCSU_READ: begin
					if (pin.done) begin
						state <= FCSU_FIN;
					end
				end
				FCSU_FIN: state <= FCSU_IDLE;
				default: state <= FCSU_IDLE;
			endcase
		end
	end

	assign busy = (state != FCSU_IDLE);

	// Pin requests per state
	assign pin.req = (state == FCSU_CMD1) || (state == FCSU_CMD2)
		|| (state == FCSU_POLL) || (state == FCSU_READ);
	assign pin.wr  = (state == FCSU_CMD1) || (state == FCSU_CMD2);
	always_comb begin
		pin.addr  = target;
		pin.wdata = 16'h0000; // Upper byte held low, a valid level [RULE16]
		if (state == FCSU_CMD1) begin
			pin.wdata = {8'h00, first_code(op)};
		end else if (state == FCSU_CMD2 && op == FCSU_OP_PROGRAM) begin
			pin.wdata = wvalue; // [RULE6]
		end else if (state == FCSU_CMD2) begin
			pin.wdata = {8'h00, FCSU_CMD_CONFIRM}; // [RULE7]
		end
		if (state == FCSU_READ && op == FCSU_OP_READ_IDENT) begin
			pin.addr = {{(AW-1){1'b0}}, target[0]}; // [RULE3]
		end
	end

	// Capture read results; status keeps only the defined bits
	always_ff @(posedge clock) begin
		if (srst) begin
			rvalue           <= 16'h0000;
			operation_status <= 8'h00;
		end else if (pin.done && !pin.wr) begin
			rvalue <= pin.rdata;
			if (state == FCSU_POLL || op == FCSU_OP_READ_STATUS) begin
				operation_status <= pin.rdata[7:0] & FCSU_SR_MASK; // [RULE15] [RULE18]
			end
		end
	end

	fcsu_pin_cycle #(.AW(AW)) u_pin (
		.clock      (clock),
		.srst       (srst),
		.bus        (pin.slave),
		.mem_addr   (mem_addr),
		.mem_ce_n   (mem_ce_n),
		.mem_oe_n   (mem_oe_n),
		.mem_we_n   (mem_we_n),
		.mem_dq_out (mem_dq_out),
		.mem_dq_oe  (mem_dq_oe),
		.mem_dq_in  (mem_dq_in)
	);

	AST_SETUP_CODE: assert property (@(posedge clock) disable iff (srst) // [RULE6]
		$fell(mem_we_n) && state == FCSU_CMD1 && op == FCSU_OP_PROGRAM
		|-> mem_dq_out[7:0] == FCSU_CMD_PROG_SETUP)
		else $error("program setup code wrong");
	AST_ERASE_CONF: assert property (@(posedge clock) disable iff (srst) // [RULE7]
		$fell(mem_we_n) && state == FCSU_CMD2 && op == FCSU_OP_ERASE
		|-> mem_dq_out[7:0] == FCSU_CMD_CONFIRM)
		else $error("erase confirm code wrong");
	AST_SAME_ADDR: assert property (@(posedge clock) disable iff (srst) // [RULE7]
		$fell(mem_we_n) && state == FCSU_CMD2 |-> mem_addr == target)
		else $error("second write at other address");
	AST_UPPER_LOW: assert property (@(posedge clock) disable iff (srst) // [RULE16]
		!mem_we_n && state == FCSU_CMD1 |-> mem_dq_out[15:8] == 8'h00)
		else $error("upper byte not driven low");
	AST_POLL_EXIT: assert property (@(posedge clock) disable iff (srst) // [RULE11]
		state == FCSU_POLLC && !pin.rdata[FCSU_SR_READY] |=> state == FCSU_POLL)
		else $error("poll left while busy");
	AST_MASK: assert property (@(posedge clock) disable iff (srst) // [RULE15]
		operation_status[2:0] == 3'h0)
		else $error("reserved status bits kept");
	AST_CLEAR_CODE: assert property (@(posedge clock) disable iff (srst) // [RULE1]
		$fell(mem_we_n) && op == FCSU_OP_CLEAR |-> mem_dq_out[7:0] == FCSU_CMD_CLEAR_STATUS)
		else $error("clear code wrong");
	AST_ID_ADDR: assert property (@(posedge clock) disable iff (srst) // [RULE3]
		$fell(mem_oe_n) && state == FCSU_READ && op == FCSU_OP_READ_IDENT
		|-> mem_addr[AW-1:1] == '0)
		else $error("identifier address not bit zero only");
	AST_DQ_DRIVE: assert property (@(posedge clock) disable iff (srst) // [RULE16]
		!mem_we_n |-> !mem_dq_oe)
		else $error("data bus not driven during command write");
	AST_POLL_READ: assert property (@(posedge clock) disable iff (srst) // [RULE17]
		state == FCSU_POLL && !mem_ce_n |-> !mem_oe_n && mem_we_n)
		else $error("poll cycle is not a fresh read");
	AST_FIN_READY: assert property (@(posedge clock) disable iff (srst) // [RULE11]
		state == FCSU_FIN && wait_ready && op != FCSU_OP_RESUME
		|-> operation_status[FCSU_SR_READY])
		else $error("poll ended without ready status");
endmodule : fcsu_host
`default_nettype wire

// ---- tb/fcsu_flash_model.sv ----
// Behavioural boot-block flash seen from its parallel pins
`timescale 1ns/1ps
`default_nettype none
module fcsu_flash_model #(
	parameter int         AW          = 20,
	parameter int         BUSY_NS     = 2000,
	parameter logic [7:0] MAKER_CODE  = 8'hA5, // Arbitrary value
	parameter logic [7:0] DEVICE_CODE = 8'h3C  // Arbitrary value
) (
	input  wire logic [AW-1:0] mem_addr,
	input  wire logic          mem_ce_n,
	input  wire logic          mem_oe_n,
	input  wire logic          mem_we_n,
	input  wire logic [15:0]   mem_dq_out,
	output logic [15:0]        mem_dq_in,
	input  wire logic          fail_prog,
	input  wire logic          fail_erase,
	input  wire logic          supply_low
);
	logic          paused = 1'b0;
	logic          efail  = 1'b0;
	logic          pfail  = 1'b0;
	logic          vlow   = 1'b0;
	logic [1:0]    mode   = 2'd0;
	logic [1:0]    pend   = 2'd0;
	logic [1:0]    kind   = 2'd0;
	logic          wr_on  = 1'b0;
	logic          rd_on  = 1'b0;
	realtime       done_at;
	logic [AW-1:0] wa, last_pa, last_ba, last_ca;
	logic [15:0]   wd, last_pd;
	logic [15:0]   last = 16'h0000;
	logic [7:0]    last_cmd;
	initial mem_dq_in = 16'hA5A5;
	task automatic settle();
		if (kind != 2'd0 && !paused && $realtime >= done_at) begin
			efail |= (kind == 2'd2 && fail_erase);
			pfail |= (kind == 2'd1 && fail_prog);
			kind = 2'd0;
		end
	endtask
	task automatic start(input logic [1:0] k);
		mode = 2'd2;
		if (supply_low) begin // Supply only looked at here
			vlow = 1'b1;
			pfail |= (k == 2'd1);
			efail |= (k == 2'd2);
		end else begin
			kind = k;
			done_at = $realtime + BUSY_NS;
		end
	endtask
	task automatic take(input logic [AW-1:0] a, input logic [7:0] d);
		logic [1:0] p;
		settle();
		last_cmd = d;
		p = pend;
		pend = 2'd0;
		if (p == 2'd1) begin
			last_pa = a;
			last_pd = wd;
			start(2'd1);
		end else if (p == 2'd2) begin
			last_ca = a;
			if (d == 8'hD0) start(2'd2);
			else begin
				{efail, pfail} = 2'b11;
				mode = 2'd2;
			end
		end else if (kind == 2'd2 && !paused) begin
			if (d == 8'hB0) paused = 1'b1;
			mode = 2'd2;
		end else if (kind == 2'd0 || paused) begin
			case (d)
				8'hFF: mode = 2'd0;
				8'h90: mode = 2'd1;
				8'h70: mode = 2'd2;
				8'h50: {efail, pfail, vlow} = 3'b000;
				8'h40, 8'h10: begin
					pend = 2'd1;
					mode = 2'd2;
				end
				8'h20: begin
					pend = 2'd2;
					last_ba = a;
					mode = 2'd2;
				end
				8'hD0: begin
					if (paused) done_at = $realtime + BUSY_NS;
					paused = 1'b0;
					mode = 2'd2;
				end
				default: ;
			endcase
		end
	endtask
	always @(mem_ce_n or mem_we_n) begin
		if (!mem_ce_n && !mem_we_n) begin
			wr_on = 1'b1;
		end else if (wr_on) begin
			// Taken at the rising strobe; data may trail the falling one
			wa = mem_addr;
			wd = mem_dq_out;
			wr_on = 1'b0;
			take(wa, wd[7:0]);
		end
	end
	always @(mem_ce_n or mem_oe_n) begin
		if (!mem_ce_n && !mem_oe_n) begin
			if (!rd_on) begin // Latched at the later strobe fall
				settle();
				rd_on = 1'b1;
				case (mode)
					2'd1: last = {8'h00, mem_addr[0] ? DEVICE_CODE : MAKER_CODE};
					2'd2: last = {8'h00, (kind == 2'd0 || paused), paused, efail, pfail, vlow,
						3'b000};
					default: last = 16'hFFFF;
				endcase
				mem_dq_in = last;
			end
		end else begin
			rd_on = 1'b0;
			mem_dq_in = ~last; // Released bus must not look valid
		end
	end
endmodule // fcsu_flash_model
`default_nettype wire

// ---- tb/fcsu_host_tb.sv ----
// Self-checking bench for the flash command host
`timescale 1ns/1ps
`default_nettype none
module fcsu_host_tb import fcsu_pkg::*;;
	localparam logic [7:0] MAKER = 8'hA5; // Arbitrary value
	localparam logic [7:0] DEV   = 8'h3C; // Arbitrary value
	logic        clock, srst, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [19:0] mem_addr;
	logic        ce_n, oe_n, we_n, dq_oe, fail_prog, fail_erase, supply_low;
	logic [15:0] dq_out, dq_in;
	int          fails, total_checks;
	fcsu_host #(.AW(20)) DUT (.clock(clock), .srst(srst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.mem_addr(mem_addr), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
		.mem_dq_out(dq_out), .mem_dq_oe(dq_oe), .mem_dq_in(dq_in));
	fcsu_flash_model #(.AW(20), .BUSY_NS(2000), .MAKER_CODE(MAKER), .DEVICE_CODE(DEV)) M (
		.mem_addr(mem_addr), .mem_ce_n(ce_n), .mem_oe_n(oe_n), .mem_we_n(we_n),
		.mem_dq_out(dq_out), .mem_dq_in(dq_in), .fail_prog(fail_prog),
		.fail_erase(fail_erase), .supply_low(supply_low));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic tick(inout int n, input int lim);
		@(posedge clock);
		n++;
		if (n > lim) begin
			fails++;
			$display("mismatch at %0t: wait ran out", $time);
			final_report();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n = 0;
		bit aw_open = 1'b1;
		bit w_open = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			tick(n, 200);
			if (aw_open && awready === 1'b1) begin
				aw_open = 1'b0;
				awvalid <= 1'b0;
			end
			if (w_open && wready === 1'b1) begin
				w_open = 1'b0;
				wvalid <= 1'b0;
			end
		end while (aw_open || w_open);
		do tick(n, 200); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd_reg(input logic [4:0] a);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(n, 200); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do tick(n, 200); while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic idle();
		int n = 0;
		do begin
			rd_reg(FCSU_REG_CTRL);
			tick(n, 3000);
		end while (rd[8] !== 1'b0);
	endtask
	task automatic op(input logic [2:0] code, input bit wait_idle);
		wr(FCSU_REG_CTRL, {24'h0, 5'h10, code});
		if (wait_idle) idle();
	endtask
	task automatic s_ident();
		wr(FCSU_REG_ADDR, 32'h000FFFFE);
		op(FCSU_OP_READ_IDENT, 1);
		rd_reg(FCSU_REG_RDATA);
		check(rd, {24'h0, MAKER});
		wr(FCSU_REG_ADDR, 32'h00000001);
		op(FCSU_OP_READ_IDENT, 1);
		rd_reg(FCSU_REG_RDATA);
		check(rd, {24'h0, DEV});
	endtask
	task automatic s_prog();
		op(FCSU_OP_CLEAR, 1);
		wr(FCSU_REG_ADDR, 32'h00000123);
		wr(FCSU_REG_WDATA, 32'h00005A0F);
		fail_prog <= 1'b1;
		op(FCSU_OP_PROGRAM, 1);
		check(32'(M.last_pa), 32'h123);
		check(32'(M.last_pd), 32'h5A0F);
		fail_prog <= 1'b0;
		op(FCSU_OP_PROGRAM, 1);
		rd_reg(FCSU_REG_STATUS);
		check(rd, 32'h90);
		op(FCSU_OP_READ_STATUS, 1);
		rd_reg(FCSU_REG_STATUS);
		check(rd, 32'h90);
		op(FCSU_OP_CLEAR, 1);
		op(FCSU_OP_READ_STATUS, 1);
		rd_reg(FCSU_REG_STATUS);
		check(rd, 32'h80);
		rd_reg(FCSU_REG_RDATA);
		check(rd, 32'h80);
		supply_low <= 1'b1;
		op(FCSU_OP_PROGRAM, 1);
		rd_reg(FCSU_REG_STATUS);
		check(rd, 32'h98);
		supply_low <= 1'b0;
		op(FCSU_OP_CLEAR, 1);
	endtask
	task automatic s_erase();
		fail_erase <= 1'b1;
		wr(FCSU_REG_ADDR, 32'h00040010);
		op(FCSU_OP_ERASE, 0);
		rd_reg(FCSU_REG_CTRL);
		check(32'(rd[8]), 32'h1);
		// Both writes land while busy and must be dropped
		wr(FCSU_REG_ADDR, 32'h00000777);
		op(FCSU_OP_CLEAR, 0);
		idle();
		rd_reg(FCSU_REG_ADDR);
		check(rd, 32'h00040010);
		check(32'(M.last_ba), 32'h40010);
		check(32'(M.last_ca), 32'h40010);
		rd_reg(FCSU_REG_STATUS);
		check(rd, 32'hA0);
		fail_erase <= 1'b0;
		op(FCSU_OP_CLEAR, 1);
	endtask
	task automatic s_codes();
		logic [2:0] ops [5];
		logic [7:0] cmds [5];
		ops = '{FCSU_OP_READ_STATUS, FCSU_OP_CLEAR, FCSU_OP_SUSPEND, FCSU_OP_RESUME,
			FCSU_OP_READ_ARRAY};
		cmds = '{8'h70, 8'h50, 8'hB0, 8'hD0, 8'hFF};
		for (int i = 0; i < 5; i++) begin
			op(ops[i], 1);
			check(32'(M.last_cmd), 32'(cmds[i]));
			check(32'(M.wd[15:8]), 32'h0);
		end
	endtask
	initial begin
		srst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = {10'h000, 32'h0, 4'hF};
		{fail_prog, fail_erase, supply_low} = 3'b000;
		fails = 0;
		total_checks = 0;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
		wr(5'h14, 32'h1);
		check(32'(resp), 32'h2);
		rd_reg(5'h1C);
		check(32'(resp), 32'h2);
		s_ident();
		s_prog();
		s_erase();
		s_codes();
		final_report();
	end
endmodule // fcsu_host_tb
`default_nettype wire
